// File: design/asp_pkg.sv
// Constants shared by the sample packetizer and its testbench.
package asp_pkg;

  // ==========================================================
  // Register map (byte offsets on the peripheral access path)
  localparam logic [7:0] IN_CTRL_FIRST = 8'h00;
  localparam logic [7:0] IN_CTRL_LAST  = 8'h1c;
  localparam logic [7:0] INPUT6_OFF    = 8'h18;
  localparam logic [7:0] INPUT7_OFF    = 8'h1c;
  localparam logic [7:0] GEN_CTRL_OFF  = 8'h20;

  // ==========================================================
  // Field positions
  localparam int DEST_MSB  = 31;
  localparam int DEST_LSB  = 8;
  localparam int IN_EN_BIT = 0;
  localparam int DROP_BIT  = 24;
  localparam int WIDTH_HI  = 17;
  localparam int WIDTH_LO  = 16;
  localparam int SPP_HI    = 15;
  localparam int SPP_LO    = 8;
  localparam int CAL_BIT   = 1;
  localparam int EN_BIT    = 0;

  // ==========================================================
  // Values after reset
  localparam logic       DROP_RST  = 1'b1;
  localparam logic [1:0] WIDTH_RST = 2'h1;
  localparam logic [7:0] SPP_RST   = 8'h01;

  // ==========================================================
  // Sample width codes
  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h3;

  // ==========================================================
  // Sizes and counts
  localparam int         NUM_INPUTS = 8;
  localparam int         RES_W      = 12;
  localparam int         DEST_W     = 24;
  localparam int         FIFO_DEPTH = 8;
  localparam int         FIFO_W     = 17;
  localparam logic [2:0] CAL_PULSES = 3'h6;

endpackage

// File: design/asp_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module asp_fifo #(
  parameter int W = 17,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wptr;
    logic [AW-1:0]       rptr;
    logic [AW:0]         count;
  } asp_fifo_state_t;

  asp_fifo_state_t st_reg;
  asp_fifo_state_t st_next;
  logic            push;
  logic            pop;

  assign in_ready  = (st_reg.count != D[AW:0]);
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rptr];

  always_comb begin
    st_next = st_reg;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr = (st_reg.wptr == AW'(D - 1)) ? '0 : st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = (st_reg.rptr == AW'(D - 1)) ? '0 : st_reg.rptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// File: design/asp_packetizer.sv
// Converter control registers, sample sequencing and packet sender.
//
// Notes on behaviour
// - Each input register bits 31:8 hold the top 24 destination id bits.
// - Input register bit 0 enables the input; resets zero; bits 7:1 read zero.
// - General bit 24 flags a lost sample and clears when read.
// - Samples are always left aligned in the transmitted word.
// - A packet ends after the configured number of samples.
// - With count zero a packet stays open until a register access.
// - General bit 1 selects the internal calibration reference.
// - General bit 0 enables; input registers then ignore writes.
// - Six pulses after each enable calibrate and send nothing.
// - From the seventh pulse on each pulse delivers a sample.
// - The calibration count restarts on every enable rise.
// - Each trigger rising edge converts the next enabled input.
// - Conversion results are twelve bits wide.
`timescale 1ns/1ps
module asp_packetizer
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Register access, whole words only
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  // Sample trigger pin
  input  wire logic              sample_trig,
  // Converter core
  output logic                   conv_start,
  output logic      [2:0]        conv_sel,
  output logic                   conv_cal_ref,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_result,
  // Outgoing channel, one byte or end token per beat
  output logic                   tx_valid,
  output logic      [7:0]        tx_data,
  output logic      [DEST_W-1:0] tx_dest,
  output logic                   tx_end,
  input  wire logic              tx_ready
);

  // ==========================================================
  // State
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BYTE = 2'b01,
    S_END  = 2'b10
  } asp_ser_t;

  typedef struct packed {
    logic [NUM_INPUTS-1:0][DEST_W-1:0] dest;
    logic [NUM_INPUTS-1:0]             in_en;
    logic                              gen_en;
    logic                              cal_sel;
    logic [1:0]                        width;
    logic [7:0]                        spp;
    logic                              drop;
    logic [2:0]                        trig_sync;
    logic [2:0]                        cal_cnt;
    logic [2:0]                        last_idx;
    logic                              busy;
    logic                              keep;
    logic [2:0]                        conv_idx;
    logic                              conv_start;
    logic                              cal_ref;
    logic [31:0]                       rdata;
    logic                              rvalid;
    logic [NUM_INPUTS-1:0]             open;
    logic [NUM_INPUTS-1:0]             close_req;
    logic [NUM_INPUTS-1:0][7:0]        cnt;
    asp_ser_t                          ser;
    logic [2:0]                        tx_idx;
    logic [23:0]                       shift;
    logic [1:0]                        left;
    logic                              tx_valid;
    logic [7:0]                        tx_data;
    logic [DEST_W-1:0]                 tx_dest;
    logic                              tx_end;
  } asp_state_t;

  asp_state_t          st_reg;
  asp_state_t          st_next;
  logic                trig_edge;
  logic                drop_evt;
  logic                in_hit;
  logic                gen_hit;
  logic [2:0]          in_idx;
  logic [2:0]          pick;
  logic [2:0]          nxt;
  logic                conv_free;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic [FIFO_W-1:0]   fifo_in_data;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [FIFO_W-1:0]   fifo_out_data;
  logic [RES_W-1:0]    pop_res;
  logic [1:0]          pop_wid;
  logic [2:0]          pop_idx;
  logic                pkt_full;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] next_input(input logic [2:0] last,
                                            input logic [7:0] en);
    logic [2:0] j;
    next_input = last;
    for (int k = NUM_INPUTS; k >= 1; k--) begin
      j = 3'(int'(last) + k);
      if (en[j]) begin
        next_input = j;
      end
    end
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] v);
    lowest = 3'h0;
    for (int k = NUM_INPUTS - 1; k >= 0; k--) begin
      if (v[k]) begin
        lowest = 3'(k);
      end
    end
  endfunction

  // ==========================================================
  // Sample path buffer
  asp_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_in_data = {st_reg.conv_idx, conv_result, st_reg.width};
  assign pop_idx      = fifo_out_data[16:14];
  assign pop_res      = fifo_out_data[13:2];
  assign pop_wid      = fifo_out_data[1:0];

  // ==========================================================
  // Next state
  always_comb begin
    st_next            = st_reg;
    st_next.conv_start = 1'b0;
    st_next.rvalid     = 1'b0;
    drop_evt           = 1'b0;
    fifo_in_valid      = 1'b0;
    fifo_out_ready     = 1'b0;
    // Only the second and third stages are looked at by the edge detector.
    st_next.trig_sync  = {st_reg.trig_sync[1:0], sample_trig};
    trig_edge          = st_reg.trig_sync[1] & ~st_reg.trig_sync[2];
    in_hit  = (reg_addr <= IN_CTRL_LAST) && (reg_addr[1:0] == 2'h0);
    gen_hit = (reg_addr == GEN_CTRL_OFF);
    in_idx  = reg_addr[4:2];
    pick    = lowest(st_reg.close_req);
    nxt     = next_input(st_reg.last_idx, st_reg.in_en);

    // Register writes.
    if (reg_wr && in_hit && !st_reg.gen_en) begin
      st_next.dest[in_idx]  = reg_wdata[DEST_MSB:DEST_LSB];
      st_next.in_en[in_idx] = reg_wdata[IN_EN_BIT];
    end
    if (reg_wr && gen_hit) begin
      st_next.gen_en  = reg_wdata[EN_BIT];
      st_next.cal_sel = reg_wdata[CAL_BIT];
      st_next.width   = reg_wdata[WIDTH_HI:WIDTH_LO];
      st_next.spp     = reg_wdata[SPP_HI:SPP_LO];
      if (reg_wdata[EN_BIT] && !st_reg.gen_en) begin
        st_next.cal_cnt = 3'h0;
      end
    end

    // Register reads answer one cycle later; reserved bits read zero.
    if (reg_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = 32'h0;
      if (in_hit) begin
        st_next.rdata[DEST_MSB:DEST_LSB] = st_reg.dest[in_idx];
        st_next.rdata[IN_EN_BIT]         = st_reg.in_en[in_idx];
      end else if (gen_hit) begin
        st_next.rdata[DROP_BIT]          = st_reg.drop;
        st_next.rdata[WIDTH_HI:WIDTH_LO] = st_reg.width;
        st_next.rdata[SPP_HI:SPP_LO]     = st_reg.spp;
        st_next.rdata[CAL_BIT]           = st_reg.cal_sel;
        st_next.rdata[EN_BIT]            = st_reg.gen_en;
      end
    end

    // Any register access ends every open packet.
    if (reg_wr || reg_rd) begin
      st_next.close_req = st_reg.close_req | st_reg.open;
    end

    // Conversion results; calibration results are thrown away.
    if (conv_done && st_reg.busy) begin
      st_next.busy = 1'b0;
      if (st_reg.keep) begin
        fifo_in_valid = 1'b1;
        if (!fifo_in_ready) begin
          drop_evt = 1'b1;
        end
      end
    end
    conv_free = !st_reg.busy || conv_done;

    // Trigger edges start conversions in round-robin order.
    if (trig_edge && st_reg.gen_en && (|st_reg.in_en)) begin
      if (!conv_free) begin
        drop_evt = 1'b1;
      end else begin
        st_next.conv_start = 1'b1;
        st_next.busy       = 1'b1;
        st_next.conv_idx   = nxt;
        st_next.last_idx   = nxt;
        st_next.cal_ref    = st_reg.cal_sel;
        st_next.keep       = (st_reg.cal_cnt == CAL_PULSES);
        if (st_reg.cal_cnt != CAL_PULSES) begin
          st_next.cal_cnt = st_reg.cal_cnt + 3'h1;
        end
      end
    end

    // Dropped flag: a new loss beats the clear by read.
    if (reg_rd && gen_hit) begin
      st_next.drop = 1'b0;
    end
    if (drop_evt) begin
      st_next.drop = 1'b1;
    end

    // Byte sender; a zero count never fills a packet.
    pkt_full = (st_reg.spp != 8'h00) &&
               (st_reg.cnt[st_reg.tx_idx] + 8'h01 == st_reg.spp);
    unique case (st_reg.ser)
      S_IDLE: begin
        if (|st_reg.close_req) begin
          st_next.ser      = S_END;
          st_next.tx_idx   = pick;
          st_next.tx_valid = 1'b1;
          st_next.tx_end   = 1'b1;
          st_next.tx_data  = 8'h00;
          st_next.tx_dest  = st_reg.dest[pick];
        end else if (fifo_out_valid) begin
          fifo_out_ready        = 1'b1;
          st_next.ser           = S_BYTE;
          st_next.tx_idx        = pop_idx;
          st_next.tx_valid      = 1'b1;
          st_next.tx_end        = 1'b0;
          st_next.tx_dest       = st_reg.dest[pop_idx];
          st_next.open[pop_idx] = 1'b1;
          // Left aligned: the top eight result bits always go first.
          st_next.tx_data = pop_res[RES_W-1:RES_W-8];
          st_next.shift   = {pop_res[3:0], 20'h00000};
          if (pop_wid == WID_8) begin
            st_next.left = 2'h0;
          end else if (pop_wid == WID_32) begin
            st_next.left = 2'h3;
          end else begin
            // The reserved code is sent as sixteen bits.
            st_next.left = 2'h1;
          end
        end
      end
      S_BYTE: begin
        if (tx_ready) begin
          if (st_reg.left != 2'h0) begin
            st_next.tx_data = st_reg.shift[23:16];
            st_next.shift   = {st_reg.shift[15:0], 8'h00};
            st_next.left    = st_reg.left - 2'h1;
          end else if (pkt_full) begin
            st_next.ser     = S_END;
            st_next.tx_end  = 1'b1;
            st_next.tx_data = 8'h00;
          end else begin
            // The packet stays open for more samples.
            st_next.ser                = S_IDLE;
            st_next.tx_valid           = 1'b0;
            st_next.cnt[st_reg.tx_idx] = st_reg.cnt[st_reg.tx_idx] + 8'h01;
          end
        end
      end
      S_END: begin
        if (tx_ready) begin
          st_next.ser                      = S_IDLE;
          st_next.tx_valid                 = 1'b0;
          st_next.tx_end                   = 1'b0;
          st_next.open[st_reg.tx_idx]      = 1'b0;
          st_next.close_req[st_reg.tx_idx] = 1'b0;
          st_next.cnt[st_reg.tx_idx]       = 8'h00;
        end
      end
      default: begin
        st_next.ser = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg       <= '0;
      st_reg.drop  <= DROP_RST;
      st_reg.width <= WIDTH_RST;
      st_reg.spp   <= SPP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign reg_rdata    = st_reg.rdata;
  assign reg_rvalid   = st_reg.rvalid;
  assign conv_start   = st_reg.conv_start;
  assign conv_sel     = st_reg.conv_idx;
  assign conv_cal_ref = st_reg.cal_ref;
  assign tx_valid     = st_reg.tx_valid;
  assign tx_data      = st_reg.tx_data;
  assign tx_dest      = st_reg.tx_dest;
  assign tx_end       = st_reg.tx_end;

  // ==========================================================
  // Checks
  a_inputs_locked : assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && in_hit && st_reg.gen_en |=>
    $stable(st_reg.dest) && $stable(st_reg.in_en))
    else $error("input register changed while enabled");
  a_drop_sets : assert property (@(posedge clk) disable iff (!nrst)
    drop_evt |=> st_reg.drop)
    else $error("lost sample not flagged");
  a_drop_clears : assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && gen_hit && !drop_evt |=> !st_reg.drop)
    else $error("dropped flag not cleared by read");
  a_beat_held : assert property (@(posedge clk) disable iff (!nrst)
    st_reg.tx_valid && !tx_ready |=> st_reg.tx_valid &&
    $stable(st_reg.tx_data) && $stable(st_reg.tx_end))
    else $error("beat changed before it was taken");
  a_cal_silent : assert property (@(posedge clk) disable iff (!nrst)
    st_reg.busy && conv_done && !st_reg.keep |-> !fifo_in_valid)
    else $error("calibration result was queued");
  a_start_enabled : assert property (@(posedge clk) disable iff (!nrst)
    st_reg.conv_start |->
    $past(st_reg.gen_en) && st_reg.in_en[st_reg.conv_idx])
    else $error("conversion of a disabled input");

endmodule

// File: verification/asp_rx_model.sv
// Receiving channel-end model that accepts packet beats with stalls.
`timescale 1ns/1ps
module asp_rx_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Incoming beats
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_end,
  output logic            tx_ready,
  // Test control and accepted beat report
  input  wire logic       hold,
  output logic            got,
  output logic [8:0]      beat
);
  // ==========================================================
  // Random stalls make the sender hold each beat until it is taken.
  initial tx_ready = 1'b0;
  initial got = 1'b0;
  always @(posedge clk) begin
    got <= nrst && tx_valid && tx_ready;
    beat <= {tx_end, tx_data};
    tx_ready <= nrst && !hold && ($urandom_range(3) != 0);
  end
endmodule

// File: verification/asp_packetizer_tb.sv
// Self-checking testbench for the sample packetizer.
`timescale 1ns/1ps
module asp_packetizer_tb;
  import asp_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              sample_trig = 1'b0;
  logic              conv_done = 1'b0;
  logic              hold = 1'b0;
  logic              ign = 1'b0;
  logic              cal = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0, reg_rdata, rd;
  logic              reg_rvalid, conv_start, conv_cal_ref;
  logic [2:0]        conv_sel, sel_seen, last_sel;
  logic [RES_W-1:0]  conv_result = 12'h000, next_v;
  logic              tx_valid, tx_end, tx_ready, got;
  logic [7:0]        tx_data;
  logic [DEST_W-1:0] tx_dest, exp_dest;
  logic [8:0]        beat;
  logic [1:0]        wid = 2'h1;
  logic [1:0]        wl[3] = '{WID_8, WID_16, WID_32};
  logic [8:0]        exp_q[$];
  int                err_count = 0, n_compared = 0, n_starts = 0, cdly = 0;

  always #2.5 clk = ~clk;

  asp_packetizer i_asp_packetizer (.clk, .nrst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .sample_trig,
    .conv_start, .conv_sel, .conv_cal_ref, .conv_done, .conv_result,
    .tx_valid, .tx_data, .tx_dest, .tx_end, .tx_ready);
  asp_rx_model i_asp_rx_model (.clk, .nrst, .tx_valid, .tx_data,
    .tx_end, .tx_ready, .hold, .got, .beat);

  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // ==========================================================
  // Converter core stand-in: a result four cycles after each start.
  always @(posedge clk) begin
    conv_done <= (cdly == 1);
    if (cdly > 0) cdly <= cdly - 1;
    if (conv_start === 1'b1) begin
      cdly <= 4;
      conv_result <= next_v;
      sel_seen <= conv_sel;
      n_starts <= n_starts + 1;
    end
  end

  // Every accepted beat is compared with the reference queue while ign is low.
  always @(posedge clk) begin
    if (tx_valid && tx_ready && !ign)
      chk(tx_dest, exp_dest, "dest");
    if (got && !ign) begin
      chk({beat[8], beat[8] ? 8'h00 : beat[7:0]},
          exp_q.size() ? exp_q[0] : 9'h1ff, "beat");
      if (exp_q.size()) void'(exp_q.pop_front());
    end
  end

  // Whole 32-bit accesses only.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd = reg_rdata;
  endtask

  task automatic gen(input logic en);
    wr(GEN_CTRL_OFF, {14'h0000, wid, 8'h01, 6'h00, cal, en});
  endtask

  task automatic pulse(input bit pkt, input int gap);
    logic [31:0] w;
    int n, s;
    n = 0;
    s = n_starts;
    next_v = RES_W'($urandom);
    w = {next_v, 20'h00000};
    @(posedge clk);
    sample_trig <= 1'b1;
    repeat (2) @(posedge clk);
    sample_trig <= 1'b0;
    while (n_starts == s && n < 20) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk(n_starts, s + 1, "start");
    chk(conv_cal_ref, cal, "cal ref");
    if (last_sel != 3'h0)
      chk(sel_seen, last_sel == 3'h6 ? 3'h7 : 3'h6, "order");
    last_sel = sel_seen;
    exp_dest = sel_seen == 3'h6 ? 24'habcdef : 24'h123456;
    if (pkt) begin
      for (int i = 0; i < (wid == WID_8 ? 1 : wid == WID_16 ? 2 : 4); i++)
        exp_q.push_back({1'b0, w[31-8*i -: 8]});
      exp_q.push_back(9'h100);
    end
    repeat (gap) @(posedge clk);
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    print_verdict;
  end

  // ==========================================================
  initial begin
    void'($urandom(88));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdr(GEN_CTRL_OFF);
    chk(rd, 32'h0101_0100, "gen reset");
    rdr(GEN_CTRL_OFF);
    chk(rd, 32'h0001_0100, "drop clear");
    rdr(INPUT6_OFF);
    chk(rd, 32'h0, "in6 reset");
    wr(INPUT6_OFF, 32'habcdef_ff);
    wr(INPUT7_OFF, 32'h123456_01);
    rdr(INPUT6_OFF);
    chk(rd, 32'habcdef_01, "in6 fields");
    $display("registers test done");
    for (int k = 0; k < 3; k++) begin
      wid = wl[k];
      cal = k[0];
      last_sel = 3'h0;
      gen(1'b0);
      gen(1'b1);
      repeat (6) pulse(0, 10);
      repeat (5) pulse(1, 40);
      chk(exp_q.size(), 0, "all beats");
    end
    $display("width test done");
    wr(INPUT6_OFF, 32'h0);
    rdr(INPUT6_OFF);
    chk(rd, 32'habcdef_01, "locked");
    $display("lock test done");
    ign = 1'b1;
    hold = 1'b1;
    repeat (16) pulse(0, 2);
    rdr(GEN_CTRL_OFF);
    chk(rd[24], 1'b1, "dropped");
    hold = 1'b0;
    repeat (200) @(posedge clk);
    $display("drop test done");
    print_verdict;
  end
endmodule
